/* File: sim/usb_charge_port_mode_control_tb.sv */
// Self-checking bench for the charge port mode control
`timescale 1ns/10ps
`default_nettype none

module usb_charge_port_mode_control_tb;
   logic                        pclk = 1'b0;
   logic                        presetn = 1'b0;
   logic                        psel = 1'b0;
   logic                        penable = 1'b0;
   logic                        pwrite = 1'b0;
   logic [7:0]                  paddr = 8'h00;
   logic [31:0]                 pwdata = 32'h0;
   logic [31:0]                 prdata;
   logic                        pready;
   logic                        pslverr;
   charge_port_pkg::supply_t    supply = 5'h00;
   logic                        mode_select_1 = 1'b0;
   logic                        mode_select_2 = 1'b0;
   logic                        attach = 1'b0;
   logic                        cable_ra = 1'b1;
   logic                        bc_ok = 1'b1;
   logic                        hold_line = 1'b0, flip = 1'b0;
   logic                        cc1_rd, cc2_rd, cc1_ra, cc2_ra, sink_drive, div_resp;
   logic                        buck, pwm, spread, lsgd, vc1, vc2, adv;
   charge_port_pkg::dline_ctl_t dl;
   logic [31:0]                 rd;
   logic                        err;
   int                          bad_count = 0;
   int                          n_tests = 0;
   int                          exp_mode;

   ////////////////////////////////////////////////////////////////////////////////
   // Clock, design and sink
   always #50 pclk = ~pclk;

   usb_charge_port_mode_control u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .supply(supply), .mode_select_1(mode_select_1), .mode_select_2(mode_select_2), .cc1_rd(cc1_rd),
      .cc2_rd(cc2_rd), .cc1_ra(cc1_ra), .cc2_ra(cc2_ra), .dline_sink_drive(sink_drive),
      .dline_divider_resp(div_resp), .buck_enable(buck), .forced_continuous_pwm(pwm), .spread_enable(spread),
      .load_switch_gate_drive(lsgd), .vconn_cc1(vc1), .vconn_cc2(vc2), .adv_3a(adv), .dline_ctl(dl));

   usb_sink_model u_sink (.pclk(pclk), .presetn(presetn), .attach(attach), .flip(flip), .cable_ra(cable_ra),
      .bc_ok(bc_ok), .hold_line(hold_line), .cc1_rd(cc1_rd), .cc2_rd(cc2_rd), .cc1_ra(cc1_ra),
      .cc2_ra(cc2_ra), .dline_sink_drive(sink_drive), .dline_divider_resp(div_resp));

   ////////////////////////////////////////////////////////////////////////////////
   // Shared tasks
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp) begin
         bad_count++;
         $display("FAIL at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   // One APB transfer; the request is held until pready is sampled high
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
      @(posedge pclk);
      psel <= 1'b1; pwrite <= wr; paddr <= a; pwdata <= wd; penable <= 1'b0;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
      end while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0; penable <= 1'b0;
   endtask

   task automatic cyc(input int n);
      repeat (n) @(posedge pclk);
   endtask

   task automatic summarize();
      $display("Comparisons %0d, mismatches %0d", n_tests, bad_count);
      if (bad_count == 0 && n_tests > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   // Watchdog: the whole sequence needs well under 3000 cycles
   initial begin
      cyc(20000);
      bad_count++;
      summarize();
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Main sequence
   initial begin
      cyc(3);
      presetn <= 1'b1;
      apb(1'b0, charge_port_pkg::CTRL_OFS, 32'h0); chk(rd, charge_port_pkg::CTRL_RESET);
      apb(1'b0, charge_port_pkg::DEBOUNCE_OFS, 32'h0); chk(rd, charge_port_pkg::DEBOUNCE_CYC);
      apb(1'b0, charge_port_pkg::HOLD12_OFS, 32'h0); chk(rd, charge_port_pkg::HOLD12_CYC);
      apb(1'b0, 8'h10, 32'h0); chk({rd[30:0], err}, 32'h1);
      apb(1'b1, charge_port_pkg::DEBOUNCE_OFS, 32'h28);
      apb(1'b1, charge_port_pkg::HOLD12_OFS, 32'h10);
      // Input supply good but enable low: no operation starts
      supply <= 5'b01100;
      cyc(4);
      apb(1'b0, charge_port_pkg::STATUS_OFS, 32'h0); chk(32'(rd[1:0]), 32'h0);
      supply <= 5'b11100;
      cyc(4);
      apb(1'b0, charge_port_pkg::STATUS_OFS, 32'h0); chk(32'(rd[1:0]), 32'h1);
      chk(32'({buck, lsgd, vc1, vc2, dl}), 32'h0);
      // Attach with Ra on the far line; still debouncing shortly after
      {mode_select_1, mode_select_2} <= 2'b10;
      attach <= 1'b1;
      cyc(4);
      apb(1'b0, charge_port_pkg::STATUS_OFS, 32'h0); chk(32'(rd[6:0]), 32'h12);
      chk(32'(buck), 32'h0);
      cyc(50);
      chk(32'({buck, pwm, spread, lsgd, vc1, vc2}), 32'h3d);
      chk(32'(dl), 32'h1);
      // Every select code on both variants, changed while active
      for (int v = 0; v < 2; v++) begin
         for (int c = 0; c < 4; c++) begin
            apb(1'b1, charge_port_pkg::CTRL_OFS, 32'h2 | 32'(v));
            {mode_select_1, mode_select_2} <= 2'(c);
            cyc(4);
            exp_mode = (c == 2) ? 32'(charge_port_pkg::MODE_SDP) : (c == 3) ? 32'(charge_port_pkg::MODE_CDP) :
                       (c == 1 && v == 1) ? 32'(charge_port_pkg::MODE_DCP) : 32'(charge_port_pkg::MODE_RESERVED);
            apb(1'b0, charge_port_pkg::STATUS_OFS, 32'h0); chk(32'(rd[6:4]), 32'(exp_mode));
            chk(32'(adv), 32'(c == 3 || (c == 1 && v == 1)));
            chk(32'(dl.pass_switch), 32'(v == 0 && c >= 2));
         end
      end
      // DCP sequencer: divider, hold at 1.2 V, shorted, release, divider sink
      {mode_select_1, mode_select_2} <= 2'b01;
      cyc(4);
      chk(32'(dl), 32'h8);
      hold_line <= 1'b1;
      cyc(6);
      chk(32'(dl), 32'h6);
      cyc(25);
      chk(32'(dl), 32'h2);
      apb(1'b0, charge_port_pkg::STATUS_OFS, 32'h0); chk(32'(rd[9:8]), 32'h2);
      hold_line <= 1'b0;
      cyc(6);
      chk(32'(dl), 32'h8);
      bc_ok <= 1'b0;
      hold_line <= 1'b1;
      cyc(30);
      chk(32'(dl), 32'h8);
      // Current limits on the pass-switch variant in CDP
      {mode_select_1, mode_select_2} <= 2'b11;
      apb(1'b1, charge_port_pkg::CTRL_OFS, 32'h2);
      cyc(6);
      chk(32'(dl), 32'h1);
      supply <= 5'b11110;
      cyc(4);
      chk(32'(dl), 32'h0);
      supply <= 5'b11101;
      cyc(4);
      chk(32'(dl), 32'h1);
      flip <= 1'b1;
      cyc(4);
      chk(32'({vc1, vc2}), 32'h2);
      // Enable drops: everything off within four cycles
      supply <= 5'b01100;
      cyc(4);
      chk(32'({buck, vc1, vc2, dl}), 32'h0);
      summarize();
   end
endmodule
`default_nettype wire

/* File: sim/usb_sink_model.sv */
// Behavioural model of an attached portable sink and its cable
`timescale 1ns/10ps
`default_nettype none

module usb_sink_model (
   // Clock and reset
   input  wire logic pclk,
   input  wire logic presetn,
   // Scenario controls
   input  wire logic attach,
   input  wire logic flip,
   input  wire logic cable_ra,
   input  wire logic bc_ok,
   input  wire logic hold_line,
   // Pins seen by the port
   output logic      cc1_rd,
   output logic      cc2_rd,
   output logic      cc1_ra,
   output logic      cc2_ra,
   output logic      dline_sink_drive,
   output logic      dline_divider_resp
);
   // Terminations and data-line signalling, all dropped at detach so nothing stale lingers
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cc1_rd             <= 1'b0;
         cc2_rd             <= 1'b0;
         cc1_ra             <= 1'b0;
         cc2_ra             <= 1'b0;
         dline_sink_drive   <= 1'b0;
         dline_divider_resp <= 1'b0;
      end else begin
         cc1_rd             <= attach & ~flip;
         cc2_rd             <= attach & flip;
         cc1_ra             <= attach & cable_ra & flip;
         cc2_ra             <= attach & cable_ra & ~flip;
         dline_sink_drive   <= attach & hold_line;
         dline_divider_resp <= attach & hold_line & ~bc_ok;   // A sink that is not BC-compliant takes the divider
      end
   end
endmodule
`default_nettype wire

/* File: verilog/charge_port_pkg.sv */
// Package: register map, field layout, mode encodings and timing counts for the charge port mode control
package charge_port_pkg;

   // Register byte offsets
   localparam logic [7:0] CTRL_OFS    = 8'h00;
   localparam logic [7:0] STATUS_OFS  = 8'h04;
   localparam logic [7:0] DEBOUNCE_OFS = 8'h08;
   localparam logic [7:0] HOLD12_OFS  = 8'h0c;

   // Control register fields
   localparam int CTRL_VARIANT_BIT = 0;   // 1: variant without pass switches
   localparam int CTRL_SPREAD_BIT  = 1;   // Spread-spectrum dithering enable
   localparam logic [31:0] CTRL_RESET = 32'h0000_0002;

   // Status register fields
   localparam int ST_STATE_LSB   = 0;
   localparam int ST_MODE_LSB    = 4;
   localparam int ST_DCP_LSB     = 8;
   localparam int ST_BUCK_BIT    = 12;
   localparam int ST_PWM_BIT     = 13;
   localparam int ST_SWITCH_BIT  = 14;
   localparam int ST_VCONN1_BIT  = 15;
   localparam int ST_VCONN2_BIT  = 16;
   localparam int ST_ADV3A_BIT   = 17;

   // Timing: debounce and 1.2 V hold, in microseconds, and derived cycle counts at 10 MHz
   localparam int CLK_MHZ        = 10;
   localparam int DEBOUNCE_US    = 200;
   localparam int HOLD12_US      = 100;
   localparam logic [31:0] DEBOUNCE_CYC = 32'(DEBOUNCE_US * CLK_MHZ);
   localparam logic [31:0] HOLD12_CYC   = 32'(HOLD12_US * CLK_MHZ);

   // Port operating states
   typedef enum logic [1:0] {
      ST_OFF,
      ST_STANDBY,
      ST_DEBOUNCE,
      ST_ACTIVE
   } port_state_t;

   // Charging modes
   typedef enum logic [2:0] {
      MODE_RESERVED,
      MODE_TYPEC,
      MODE_SDP,
      MODE_CDP,
      MODE_DCP
   } usb_mode_t;

   // DCP auto-detect schemes
   typedef enum logic [1:0] {
      DCP_DIVIDER,
      DCP_HOLD12,
      DCP_SHORTED
   } dcp_state_t;

   // Data-line drive controls
   typedef struct packed {
      logic div_bias;      // Both lines biased to 2.7 V
      logic bias_12;       // Both lines pulled to 1.2 V
      logic short_lines;   // D+ tied to D- through low impedance
      logic pass_switch;   // Data pass switches closed
   } dline_ctl_t;

   // Analog status inputs
   typedef struct packed {
      logic en_high;
      logic vin_ok;
      logic vcc_ok;
      logic ext_fet_ilim;
      logic vconn_ilim;
   } supply_t;

endpackage

/* File: verilog/usb_charge_port_mode_control.sv */
// Mode control for a Type-C and battery-charging downstream port with step-down regulator
// What this block does
// R1: Enabled without sink on either CC line: standby, regulator off, bus at zero.
// R2: Active only with enable high, both supplies good and valid CC detection.
// R3: Active mode runs regulator in forced continuous PWM with spread-spectrum dithering.
// R4: Pass-switch variant: 00 and 01 reserved, 10 Type-C 1.5A SDP, 11 3A CDP.
// R5: No-switch variant: 01 3A auto DCP, 10 1.5A SDP, 11 3A CDP.
// R6: Mode-select inputs watched continuously; mode follows each change.
// R7: After input supply good, enable sampled; operation starts only if high.
// R8: Regulator turns on only after sink detection persists for debounce time.
// R9: Active-cable termination on the other CC line gets VCONN applied.
// R10: Always start in Type-C mode, then move to selected charging mode.
// R11: Sink drives 0.6 V on D+, reads D-: below 0.3 V means SDP.
// R12: Sink drives 0.6 V on D-, reads D+: below 0.3 V means CDP.
// R13: DCP uses one automatic state choosing shorted, divider or 1.2 V scheme.
// R14: Divider scheme biases both data lines to 2.7 V.
// R15: 1.2 V scheme shorts and pulls lines to 1.2 V, then goes shorted.
// R16: Shorted scheme ties D+ to D- through at most 200 ohms.
// R17: DCP sequencer starts in the divider scheme.
// R18: Shorted-compliant sink: brief 1.2 V scheme, then settle in shorted scheme.
// R19: Stay in 1.2 V or shorted until data line released, then divider.
// R20: Sink responding to divider scheme keeps the sequencer in divider.
// R21: Pass switches close in CDP and SDP only with enable high and attach entered.
// R22: Switches open in external-FET current limit, stay closed in VCONN limit.
// R23: Debounce and 1.2 V hold durations are configurable cycle counts.
//
// The register offsets and the APB slave port were decided locally.
`timescale 1ns/10ps
`default_nettype none

module usb_charge_port_mode_control (
   // Clock and reset
   input  wire logic                         pclk,
   input  wire logic                         presetn,
   // APB slave
   input  wire logic                         psel,
   input  wire logic                         penable,
   input  wire logic                         pwrite,
   input  wire logic [7:0]                   paddr,
   input  wire logic [31:0]                  pwdata,
   output logic      [31:0]                  prdata,
   output logic                              pready,
   output logic                              pslverr,
   // Pins and analog status
   input  wire charge_port_pkg::supply_t     supply,
   input  wire logic                         mode_select_1,
   input  wire logic                         mode_select_2,
   input  wire logic                         cc1_rd,
   input  wire logic                         cc2_rd,
   input  wire logic                         cc1_ra,
   input  wire logic                         cc2_ra,
   input  wire logic                         dline_sink_drive,
   input  wire logic                         dline_divider_resp,
   // Regulator and line controls
   output logic                              buck_enable,
   output logic                              forced_continuous_pwm,
   output logic                              spread_enable,
   output logic                              load_switch_gate_drive,
   output logic                              vconn_cc1,
   output logic                              vconn_cc2,
   output logic                              adv_3a,
   output var charge_port_pkg::dline_ctl_t   dline_ctl
);

   ////////////////////////////////////////////////////////////////////////////////
   // Registers and state

   logic [31:0]                   ctrl_q;
   logic [31:0]                   debounce_q;
   logic [31:0]                   hold12_q;
   charge_port_pkg::port_state_t  state_q;
   charge_port_pkg::usb_mode_t    mode_q;
   charge_port_pkg::usb_mode_t    sel_mode;
   charge_port_pkg::dcp_state_t   dcp_q;
   logic [31:0]                   cnt_q;
   logic [31:0]                   hcnt_q;
   logic                          sink_seen;
   logic                          supplies_ok;
   logic                          wr_en;
   logic                          rd_en;
   logic                          addr_ok;
   logic                          no_switch;

   // Attach, supply and bus qualifiers
   assign sink_seen   = cc1_rd | cc2_rd;
   assign supplies_ok = supply.en_high & supply.vin_ok & supply.vcc_ok;
   assign no_switch   = ctrl_q[charge_port_pkg::CTRL_VARIANT_BIT];
   assign wr_en       = psel & penable & pwrite;
   assign rd_en       = psel & ~penable & ~pwrite;

   // Decode a mode-select pair for the selected variant
   function automatic charge_port_pkg::usb_mode_t decode_mode(input logic [1:0] sel, input logic nosw);
      charge_port_pkg::usb_mode_t m;
      m = charge_port_pkg::MODE_RESERVED;
      unique case (sel)
         2'h1:    m = nosw ? charge_port_pkg::MODE_DCP : charge_port_pkg::MODE_RESERVED;  // R4 R5
         2'h2:    m = charge_port_pkg::MODE_SDP;                                           // R4 R5
         2'h3:    m = charge_port_pkg::MODE_CDP;                                           // R4 R5
         default: m = charge_port_pkg::MODE_RESERVED;                                      // R4
      endcase
      return m;
   endfunction

   // Address match for the four mapped words
   function automatic logic addr_hit(input logic [7:0] a);
      return (a == charge_port_pkg::CTRL_OFS) || (a == charge_port_pkg::STATUS_OFS) ||
             (a == charge_port_pkg::DEBOUNCE_OFS) || (a == charge_port_pkg::HOLD12_OFS);
   endfunction

   // Unmapped words get an error and read zero
   assign addr_ok  = addr_hit(paddr);
   assign sel_mode = decode_mode({mode_select_1, mode_select_2}, no_switch);

   ////////////////////////////////////////////////////////////////////////////////
   // APB register writes; zero-wait slave, writes land on the access cycle

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl_q     <= charge_port_pkg::CTRL_RESET;
         debounce_q <= charge_port_pkg::DEBOUNCE_CYC;
         hold12_q   <= charge_port_pkg::HOLD12_CYC;
      end else if (wr_en) begin
         if (paddr == charge_port_pkg::CTRL_OFS) begin
            ctrl_q <= pwdata;
         end
         if (paddr == charge_port_pkg::DEBOUNCE_OFS) begin
            debounce_q <= pwdata;  // R23
         end
         if (paddr == charge_port_pkg::HOLD12_OFS) begin
            hold12_q <= pwdata;    // R23
         end
      end
   end

   // Read data is captured in setup so the access cycle sees it from a flop
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= 32'h0000_0000;
      end else if (rd_en) begin
         unique case (paddr)
            charge_port_pkg::CTRL_OFS:     prdata <= ctrl_q;
            charge_port_pkg::DEBOUNCE_OFS: prdata <= debounce_q;
            charge_port_pkg::HOLD12_OFS:   prdata <= hold12_q;
            charge_port_pkg::STATUS_OFS: begin
               prdata <= 32'h0000_0000;
               prdata[charge_port_pkg::ST_STATE_LSB +: 2] <= state_q;
               prdata[charge_port_pkg::ST_MODE_LSB +: 3]  <= mode_q;
               prdata[charge_port_pkg::ST_DCP_LSB +: 2]   <= dcp_q;
               prdata[charge_port_pkg::ST_BUCK_BIT]       <= buck_enable;
               prdata[charge_port_pkg::ST_PWM_BIT]        <= forced_continuous_pwm;
               prdata[charge_port_pkg::ST_SWITCH_BIT]     <= dline_ctl.pass_switch;
               prdata[charge_port_pkg::ST_VCONN1_BIT]     <= vconn_cc1;
               prdata[charge_port_pkg::ST_VCONN2_BIT]     <= vconn_cc2;
               prdata[charge_port_pkg::ST_ADV3A_BIT]      <= adv_3a;
            end
            default: prdata <= 32'h0000_0000;
         endcase
      end
   end

   // Ready and error are flops asserted in the access cycle
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
      end else begin
         pready  <= psel & ~penable;
         pslverr <= psel & ~penable & ~addr_ok;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Port state: off, standby, attach debounce, active

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_q <= charge_port_pkg::ST_OFF;
         cnt_q   <= 32'h0000_0000;
      end else if (!supplies_ok) begin
         state_q <= charge_port_pkg::ST_OFF;                     // R2 R7
         cnt_q   <= 32'h0000_0000;
      end else begin
         unique case (state_q)
            charge_port_pkg::ST_OFF: begin
               state_q <= charge_port_pkg::ST_STANDBY;           // R7
            end
            charge_port_pkg::ST_STANDBY: begin
               // A CC glitch restarts the debounce from zero
               cnt_q <= 32'h0000_0000;
               if (sink_seen) begin
                  state_q <= charge_port_pkg::ST_DEBOUNCE;       // R1
               end
            end
            charge_port_pkg::ST_DEBOUNCE: begin
               if (!sink_seen) begin
                  state_q <= charge_port_pkg::ST_STANDBY;        // R8
               end else if (cnt_q + 32'h0000_0001 >= debounce_q) begin
                  state_q <= charge_port_pkg::ST_ACTIVE;         // R8 R2
               end else begin
                  cnt_q <= cnt_q + 32'h0000_0001;
               end
            end
            charge_port_pkg::ST_ACTIVE: begin
               if (!sink_seen) begin
                  state_q <= charge_port_pkg::ST_STANDBY;        // R1
               end
            end
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Charging mode: Type-C first, then whatever the select pins command

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mode_q <= charge_port_pkg::MODE_TYPEC;
      end else if (state_q != charge_port_pkg::ST_ACTIVE) begin
         mode_q <= charge_port_pkg::MODE_TYPEC;                  // R10
      end else begin
         // Reserved codes keep power but grant no extras
         mode_q <= sel_mode;                                     // R6 R10
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // DCP auto-detect sequencer

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         dcp_q  <= charge_port_pkg::DCP_DIVIDER;
         hcnt_q <= 32'h0000_0000;
      end else if (mode_q != charge_port_pkg::MODE_DCP) begin
         dcp_q  <= charge_port_pkg::DCP_DIVIDER;                 // R17
         hcnt_q <= 32'h0000_0000;
      end else begin
         unique case (dcp_q)
            charge_port_pkg::DCP_DIVIDER: begin
               hcnt_q <= 32'h0000_0000;
               // A divider responder keeps the divider; a driving sink goes through 1.2 V
               if (dline_sink_drive && !dline_divider_resp) begin
                  dcp_q <= charge_port_pkg::DCP_HOLD12;          // R18 R20 R13
               end
            end
            charge_port_pkg::DCP_HOLD12: begin
               // Releasing the line aborts the 1.2 V step
               if (!dline_sink_drive) begin
                  dcp_q <= charge_port_pkg::DCP_DIVIDER;         // R19
               end else if (hcnt_q + 32'h0000_0001 >= hold12_q) begin
                  dcp_q <= charge_port_pkg::DCP_SHORTED;         // R15 R18
               end else begin
                  hcnt_q <= hcnt_q + 32'h0000_0001;
               end
            end
            charge_port_pkg::DCP_SHORTED: begin
               if (!dline_sink_drive) begin
                  dcp_q <= charge_port_pkg::DCP_DIVIDER;         // R19
               end
            end
            default: dcp_q <= charge_port_pkg::DCP_DIVIDER;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Outputs, all registered

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         buck_enable            <= 1'b0;
         forced_continuous_pwm  <= 1'b0;
         spread_enable          <= 1'b0;
         load_switch_gate_drive <= 1'b0;
         vconn_cc1              <= 1'b0;
         vconn_cc2              <= 1'b0;
         adv_3a                 <= 1'b0;
         dline_ctl              <= '0;
      end else begin
         buck_enable            <= state_q == charge_port_pkg::ST_ACTIVE;   // R1 R8
         forced_continuous_pwm  <= state_q == charge_port_pkg::ST_ACTIVE;   // R3
         spread_enable          <= (state_q == charge_port_pkg::ST_ACTIVE) &&
                                   ctrl_q[charge_port_pkg::CTRL_SPREAD_BIT]; // R3
         // Gate drive tracks the regulator; FET limit cuts it
         load_switch_gate_drive <= (state_q == charge_port_pkg::ST_ACTIVE) && !supply.ext_fet_ilim;
         // VCONN goes to the CC line with Ra while the other carries the sink
         vconn_cc1 <= (state_q == charge_port_pkg::ST_ACTIVE) && cc1_ra && cc2_rd;  // R9
         vconn_cc2 <= (state_q == charge_port_pkg::ST_ACTIVE) && cc2_ra && cc1_rd;  // R9
         adv_3a    <= (mode_q == charge_port_pkg::MODE_CDP) || (mode_q == charge_port_pkg::MODE_DCP);
         dline_ctl.div_bias    <= (mode_q == charge_port_pkg::MODE_DCP) &&
                                  (dcp_q == charge_port_pkg::DCP_DIVIDER);          // R14
         dline_ctl.bias_12     <= (mode_q == charge_port_pkg::MODE_DCP) &&
                                  (dcp_q == charge_port_pkg::DCP_HOLD12);           // R15
         dline_ctl.short_lines <= (mode_q == charge_port_pkg::MODE_DCP) &&
                                  (dcp_q != charge_port_pkg::DCP_DIVIDER);          // R15 R16
         // VCONN limit deliberately does not open the switches
         dline_ctl.pass_switch <= !no_switch && supply.en_high &&
                                  (state_q == charge_port_pkg::ST_ACTIVE) &&
                                  ((mode_q == charge_port_pkg::MODE_SDP) ||
                                   (mode_q == charge_port_pkg::MODE_CDP)) &&
                                  !supply.ext_fet_ilim;                             // R21 R22 R11 R12
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Checks

   // Port state and regulator
   chk_standby_buck_off: assert property (@(posedge pclk) disable iff (!presetn)
      (state_q == charge_port_pkg::ST_STANDBY) |=> !buck_enable)  // R1
      else $error("buck on during standby");

   chk_active_needs_supply: assert property (@(posedge pclk) disable iff (!presetn)
      !supplies_ok |=> state_q == charge_port_pkg::ST_OFF)  // R2
      else $error("state not off without supplies");

   chk_pwm_with_buck: assert property (@(posedge pclk) disable iff (!presetn)
      buck_enable == forced_continuous_pwm)  // R3
      else $error("pwm mode differs from buck enable");

   // Mode decode, start-up, debounce entry and VCONN side
   chk_reserved_decode: assert property (@(posedge pclk) disable iff (!presetn)
      (state_q == charge_port_pkg::ST_ACTIVE && {mode_select_1, mode_select_2} == 2'h0 && supplies_ok && sink_seen)
      |=> mode_q == charge_port_pkg::MODE_RESERVED)  // R4
      else $error("reserved select not decoded");

   chk_dcp_decode: assert property (@(posedge pclk) disable iff (!presetn)
      (mode_q == charge_port_pkg::MODE_DCP) |-> no_switch)  // R5
      else $error("dcp on switch variant");

   chk_mode_follow: assert property (@(posedge pclk) disable iff (!presetn)
      (state_q == charge_port_pkg::ST_ACTIVE && $stable(state_q)) |=> mode_q == $past(sel_mode))  // R6
      else $error("mode did not follow select");

   chk_off_to_standby: assert property (@(posedge pclk) disable iff (!presetn)
      (state_q == charge_port_pkg::ST_OFF && supplies_ok) |=> state_q == charge_port_pkg::ST_STANDBY)  // R7
      else $error("start-up did not reach standby");

   chk_debounce_entry: assert property (@(posedge pclk) disable iff (!presetn)
      (state_q != charge_port_pkg::ST_ACTIVE) ##1 (state_q == charge_port_pkg::ST_ACTIVE)
      |-> $past(state_q) == charge_port_pkg::ST_DEBOUNCE)  // R8
      else $error("active without debounce");

   chk_vconn_side: assert property (@(posedge pclk) disable iff (!presetn)
      vconn_cc1 |-> !vconn_cc2)  // R9
      else $error("vconn on both lines");

   chk_typec_first: assert property (@(posedge pclk) disable iff (!presetn)
      (state_q != charge_port_pkg::ST_ACTIVE) |=> mode_q == charge_port_pkg::MODE_TYPEC)  // R10
      else $error("mode not type-c before active");

   // DCP sequencer and data lines
   chk_dcp_hold: assert property (@(posedge pclk) disable iff (!presetn)
      (dcp_q == charge_port_pkg::DCP_SHORTED) |-> $past(dcp_q) != charge_port_pkg::DCP_DIVIDER)  // R18
      else $error("shorted without 1.2 V step");

   chk_dcp_restart: assert property (@(posedge pclk) disable iff (!presetn)
      (mode_q != charge_port_pkg::MODE_DCP) |=> dcp_q == charge_port_pkg::DCP_DIVIDER)  // R17
      else $error("sequencer not back in divider");

   chk_hold_shorts: assert property (@(posedge pclk) disable iff (!presetn)
      dline_ctl.bias_12 |-> dline_ctl.short_lines)  // R15
      else $error("1.2 V bias without short");

   chk_switch_gate: assert property (@(posedge pclk) disable iff (!presetn)
      supply.ext_fet_ilim |=> !dline_ctl.pass_switch)  // R22
      else $error("switch closed under fet limit");

   chk_switch_enable: assert property (@(posedge pclk) disable iff (!presetn)
      !supply.en_high |=> !dline_ctl.pass_switch)  // R21
      else $error("switch closed with enable low");

endmodule

`default_nettype wire
